/* File: sbl_pkg.sv */
// package for the serial bootstrap loader: offsets, field positions, timing
// assumes a single 100 MHz clock domain and an AXI4-Lite register port
package sbl_pkg;
	// register byte offsets
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_RAMPTR = 8'h08;
	localparam logic [7:0] REG_JUMP = 8'h0C;
	localparam logic [7:0] REG_RXDATA = 8'h10;
	// field positions in the mode register
	localparam int MODE_BOOT_ROM_BIT = 0;
	localparam int MODE_SPECIAL_BIT = 1;
	localparam int MODE_A_BIT = 2;
	localparam int MODE_WIRED_OR_BIT = 3;
	localparam int MODE_ERASED_BIT = 4;
	// timing: e clock 2 MHz, system clock 100 MHz
	localparam int CLK_MHZ = 100;
	localparam int ECLK_MHZ = 2;
	localparam int E_DIV = CLK_MHZ / ECLK_MHZ;
	// default rate: prescale 4 x divider 4 x 16 = 256 e cycles per bit
	localparam int FAST_BIT_E = 4 * 4 * 16 / 16 * 16;
	// 1200 baud at 2 MHz e clock: 1666 e cycles per bit (rounded down)
	localparam int SLOW_BIT_E = 2000000 / 1200;
	localparam int LOOP_E = 19;
	localparam int FAST_LOOPS = 539;
	localparam int FAST_TMO_E = FAST_LOOPS * LOOP_E;
	// four char times of ten bits at 1200 baud
	localparam int SLOW_TMO_E = SLOW_BIT_E * 10 * 4;
	localparam int RAM_BYTES = 512;
	localparam logic [15:0] RAM_START = 16'h0000;
	localparam logic [15:0] EEPROM_START = 16'hB600;
	localparam logic [15:0] PRESET_X = 16'h1000;
	localparam logic [15:0] PRESET_Y = 16'hD000;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] SLOW_A = 8'hE0;
	localparam logic [7:0] SLOW_B = 8'hC0;
	localparam logic [7:0] BREAK_CHAR = 8'h00;
endpackage : sbl_pkg

/* File: sbl_loader.sv */
// serial bootstrap loader: mode latch, serial rx/tx, download engine, axi4-lite regs
// assumes rxd/txd are synchronous to aclk and a host that opens with an all-ones char
`timescale 1ns/1ps
// Function
// - reset into bootstrap sets boot rom enable, other modes clear it
// - in special test mode software may set boot rom enable
// - security programmed: ignore mode a input, mode b alone selects
// - secured part leaves security only after eeprom and ram erased
// - start at 7812 baud, can switch to 1200 baud
// - all-ones keeps rate; E0 or C0 switches to 1200 baud
// - receiver checks start mid-bit, samples data mid-bit, stop must be one unless the char is 00
// - host sends all ones first; first chars other than FF, E0, C0 or 00 flag an error
// - set wired-or port mode and enable rx and tx before exchange
// - transmit break; looped-back 00 jumps to eeprom start B600
// - ram pointer starts at 0000 and advances after each store
// - echo each stored byte back to the host
// - download 0 to 512 bytes, ended by four idle character times
// - 256-byte ram variant takes exactly 256 bytes, no idle end
// - default rate timeout is 539 loops of 19 e cycles
// - no timeout runs before the first all-ones char arrives
// - switching to 1200 baud swaps in a matching timeout constant
// - all-ones then timeout stores nothing and jumps to ram start
// - end on timeout or full ram, preset index regs, jump to ram
// - timeout equals four ten-bit characters at sixteen clocks per bit
// - special mode drives address bit 14 low on vector fetch
module sbl_loader #(
	parameter logic SMALL_RAM = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic mode_a_input,
	input wire logic mode_b_input,
	input wire logic security_disable_bit,
	input wire logic vector_fetch,
	input wire logic rxd,
	output logic txd,
	output logic addr14_force_low,
	output logic ram_we,
	output logic [15:0] ram_addr,
	output logic [7:0] ram_wdata,
	output logic jump_valid,
	output logic [15:0] jump_addr,
	output logic [15:0] index_x,
	output logic [15:0] index_y,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [3:0] {
		ST_INIT, ST_BREAK, ST_FIRST, ST_LOAD, ST_ECHO, ST_FINISH, ST_DONE
	} sbl_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sbl_rx_t;

	typedef struct packed {
		sbl_state_t st;
		logic boot_rom_enable;
		logic special_mode_flag;
		logic mode_a_flag;
		logic port_wired_or_select;
		logic rx_en;
		logic tx_en;
		logic slow;
		logic rx_error;
		logic secured;
		logic erased;
		logic [5:0] ediv;
		// receiver
		sbl_rx_t rxs;
		logic rx_prev;
		logic [11:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_done;
		logic [7:0] rx_byte;
		// transmitter: 10-bit frame, break sends all zeros
		logic [9:0] tx_sh;
		logic [3:0] tx_bits;
		logic [11:0] tx_cnt;
		logic txd;
		// loader
		// slow timeout is 66640 e cycles, so the counter needs 17 bits
		logic [16:0] tmo;
		logic [15:0] ptr;
		logic [15:0] jump_addr;
		logic jump_valid;
		logic [15:0] ix;
		logic [15:0] iy;
		logic ram_we;
		logic [15:0] ram_addr;
		logic [7:0] ram_wdata;
		logic a14_low;
		// bus
		logic awready;
		logic wready;
		logic have_aw;
		logic have_w;
		logic [7:0] aw;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sbl_reg_t;

	sbl_reg_t r_ff;
	sbl_reg_t nxt_r;

	// bit period in e cycles for the current rate
	function automatic logic [11:0] bit_e(input logic slow);
		return slow ? 12'(sbl_pkg::SLOW_BIT_E) : 12'(sbl_pkg::FAST_BIT_E);
	endfunction : bit_e

	// timeout in e cycles for the current rate
	function automatic logic [16:0] tmo_e(input logic slow);
		return slow ? 17'(sbl_pkg::SLOW_TMO_E) : 17'(sbl_pkg::FAST_TMO_E);
	endfunction : tmo_e

	logic etick;
	logic rx_err_set; // an error is raised this cycle; it beats a software clear
	assign etick = (r_ff.ediv == 6'(sbl_pkg::E_DIV - 1));

	// whole next-state computation
	always_comb begin
		nxt_r = r_ff;
		rx_err_set = 1'b0;
		nxt_r.ram_we = 1'b0;
		nxt_r.rx_done = 1'b0;
		nxt_r.ediv = etick ? 6'h00 : r_ff.ediv + 6'h01;
		// receiver: falling edge, confirm mid start, mid-bit data, stop must be 1 unless the char is 00
		// mid-bit sampling
		if (etick && r_ff.rx_en) begin
			nxt_r.rx_prev = rxd;
			nxt_r.rx_cnt = r_ff.rx_cnt + 12'h001;
			case (r_ff.rxs)
				RX_IDLE: begin
					nxt_r.rx_cnt = 12'h000;
					if (r_ff.rx_prev && !rxd) begin
						nxt_r.rxs = RX_START;
					end
				end
				RX_START: begin
					if (r_ff.rx_cnt == (bit_e(r_ff.slow) >> 1)) begin
						nxt_r.rx_cnt = 12'h000;
						nxt_r.rx_bit = 4'h0;
						nxt_r.rxs = rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (r_ff.rx_cnt == bit_e(r_ff.slow)) begin
						nxt_r.rx_cnt = 12'h000;
						nxt_r.rx_sh = {rxd, r_ff.rx_sh[7:1]};
						nxt_r.rx_bit = r_ff.rx_bit + 4'h1;
						if (r_ff.rx_bit == 4'h7) begin
							nxt_r.rxs = RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (r_ff.rx_cnt == bit_e(r_ff.slow)) begin
						nxt_r.rxs = RX_IDLE;
						// framing error drops the char, except an all-zero break
						if (rxd || r_ff.rx_sh == sbl_pkg::BREAK_CHAR) begin
							nxt_r.rx_done = 1'b1;
							nxt_r.rx_byte = r_ff.rx_sh;
						end else begin
							nxt_r.rx_error = 1'b1;
							rx_err_set = 1'b1;
						end
					end
				end
				default: nxt_r.rxs = RX_IDLE;
			endcase
		end
		// transmitter, lsb first; idle line high
		if (etick && r_ff.tx_bits != 4'h0) begin
			nxt_r.tx_cnt = r_ff.tx_cnt + 12'h001;
			if (r_ff.tx_cnt == bit_e(r_ff.slow) - 12'h001) begin
				nxt_r.tx_cnt = 12'h000;
				nxt_r.txd = r_ff.tx_sh[0];
				nxt_r.tx_sh = {1'b1, r_ff.tx_sh[9:1]};
				nxt_r.tx_bits = r_ff.tx_bits - 4'h1;
			end
		end else if (r_ff.tx_bits == 4'h0) begin
			nxt_r.txd = 1'b1;
		end
		// loader sequence
		case (r_ff.st)
			ST_INIT: begin
				nxt_r.port_wired_or_select = 1'b1;
				nxt_r.rx_en = 1'b1;
				nxt_r.tx_en = 1'b1;
				nxt_r.slow = 1'b0;
				nxt_r.tmo = tmo_e(1'b0);
				if (r_ff.boot_rom_enable && (!r_ff.secured || r_ff.erased)) begin
					nxt_r.st = ST_BREAK;
				end
			end
			ST_BREAK: begin
				nxt_r.tx_sh = 10'h000;
				nxt_r.tx_bits = 4'hA;
				nxt_r.tx_cnt = 12'h000;
				nxt_r.st = ST_FIRST;
			end
			ST_FIRST: begin
				// no timeout while waiting for first char
				if (r_ff.rx_done) begin
					nxt_r.ptr = sbl_pkg::RAM_START;
					nxt_r.tmo = tmo_e(1'b0);
					nxt_r.st = ST_LOAD;
					if (r_ff.rx_byte == sbl_pkg::BREAK_CHAR) begin
						nxt_r.jump_addr = sbl_pkg::EEPROM_START;
						nxt_r.st = ST_DONE;
						nxt_r.jump_valid = 1'b1;
					end else if (r_ff.rx_byte == sbl_pkg::SLOW_A ||
						r_ff.rx_byte == sbl_pkg::SLOW_B) begin
						nxt_r.slow = 1'b1;
						nxt_r.tmo = tmo_e(1'b1);
					end else if (r_ff.rx_byte != sbl_pkg::ALL_ONES) begin
						nxt_r.rx_error = 1'b1;
						rx_err_set = 1'b1;
					end
				end
			end
			ST_LOAD: begin
				if (r_ff.rx_done) begin
					nxt_r.ram_we = 1'b1;
					nxt_r.ram_addr = r_ff.ptr;
					nxt_r.ram_wdata = r_ff.rx_byte;
					nxt_r.ptr = r_ff.ptr + 16'h0001;
					nxt_r.tmo = tmo_e(r_ff.slow);
					nxt_r.st = ST_ECHO;
				// idle end, none for small ram
				end else if (etick && !SMALL_RAM) begin
					if (r_ff.tmo == 17'h00000) begin
						nxt_r.st = ST_FINISH;
					end else begin
						nxt_r.tmo = r_ff.tmo - 17'h00001;
					end
				end
			end
			ST_ECHO: begin
				if (r_ff.tx_bits == 4'h0) begin
					nxt_r.tx_sh = {1'b1, r_ff.ram_wdata, 1'b0};
					nxt_r.tx_bits = 4'hA;
					nxt_r.tx_cnt = 12'h000;
					if (r_ff.ptr == (SMALL_RAM ? 16'(sbl_pkg::RAM_BYTES / 2) :
						16'(sbl_pkg::RAM_BYTES))) begin
						nxt_r.st = ST_FINISH;
					end else begin
						nxt_r.st = ST_LOAD;
					end
				end
			end
			ST_FINISH: begin
				// preset index regs, jump to ram
				nxt_r.ix = sbl_pkg::PRESET_X;
				nxt_r.iy = sbl_pkg::PRESET_Y;
				nxt_r.jump_addr = sbl_pkg::RAM_START;
				nxt_r.jump_valid = 1'b1;
				nxt_r.st = ST_DONE;
			end
			ST_DONE: nxt_r.st = ST_DONE;
			default: nxt_r.st = ST_INIT;
		endcase
		nxt_r.a14_low = r_ff.special_mode_flag && vector_fetch;
		// axi write path: address and data in either order
		if (s_axi_awvalid && r_ff.awready) begin
			nxt_r.have_aw = 1'b1;
			nxt_r.aw = s_axi_awaddr;
			nxt_r.awready = 1'b0;
		end
		if (s_axi_wvalid && r_ff.wready) begin
			nxt_r.have_w = 1'b1;
			nxt_r.wd = s_axi_wdata;
			nxt_r.ws = s_axi_wstrb;
			nxt_r.wready = 1'b0;
		end
		if (r_ff.have_aw && r_ff.have_w && !r_ff.bvalid) begin
			nxt_r.have_aw = 1'b0;
			nxt_r.have_w = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp = 2'h0;
			if (r_ff.aw == sbl_pkg::REG_MODE) begin
				// test-mode write of boot rom enable
				if (r_ff.ws[0] && r_ff.special_mode_flag &&
					r_ff.wd[sbl_pkg::MODE_BOOT_ROM_BIT]) begin
					nxt_r.boot_rom_enable = 1'b1;
				end
				if (r_ff.ws[0] && r_ff.wd[sbl_pkg::MODE_ERASED_BIT]) begin
					nxt_r.erased = 1'b1;
				end
			end else if (r_ff.aw == sbl_pkg::REG_STAT) begin
				// write one clears the error; a new error the same cycle wins
				if (r_ff.ws[0] && r_ff.wd[0] && !rx_err_set) begin
					nxt_r.rx_error = 1'b0;
				end
			end else begin
				nxt_r.bresp = 2'h2;
			end
		end
		if (r_ff.bvalid && s_axi_bready) begin
			nxt_r.bvalid = 1'b0;
			nxt_r.awready = 1'b1;
			nxt_r.wready = 1'b1;
		end
		// axi read path, one cycle answer after address
		if (s_axi_arvalid && r_ff.arready) begin
			nxt_r.arready = 1'b0;
			nxt_r.rvalid = 1'b1;
			nxt_r.rresp = 2'h0;
			case (s_axi_araddr)
				sbl_pkg::REG_MODE: nxt_r.rdata = {27'h0, r_ff.erased,
					r_ff.port_wired_or_select, r_ff.mode_a_flag,
					r_ff.special_mode_flag, r_ff.boot_rom_enable};
				sbl_pkg::REG_STAT: nxt_r.rdata = {24'h0, r_ff.secured,
					r_ff.slow, r_ff.tx_en, r_ff.rx_en, r_ff.st};
				sbl_pkg::REG_RAMPTR: nxt_r.rdata = {16'h0, r_ff.ptr};
				sbl_pkg::REG_JUMP: nxt_r.rdata = {15'h0, r_ff.jump_valid,
					r_ff.jump_addr};
				sbl_pkg::REG_RXDATA: nxt_r.rdata = {23'h0, r_ff.rx_error,
					r_ff.rx_byte};
				default: begin
					nxt_r.rdata = 32'h0000_0000;
					nxt_r.rresp = 2'h2;
				end
			endcase
		end
		if (r_ff.rvalid && s_axi_rready) begin
			nxt_r.rvalid = 1'b0;
			nxt_r.arready = 1'b1;
		end
	end

	// state register; reset latches the mode straps on the clock edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_ff <= '0;
			r_ff.st <= ST_INIT;
			r_ff.rxs <= RX_IDLE;
			r_ff.rx_prev <= 1'b1;
			r_ff.txd <= 1'b1;
			r_ff.awready <= 1'b1;
			r_ff.wready <= 1'b1;
			r_ff.arready <= 1'b1;
			r_ff.mode_a_flag <= security_disable_bit & mode_a_input;
			r_ff.special_mode_flag <= !mode_b_input;
			// boot rom only in bootstrap mode
			r_ff.boot_rom_enable <= !mode_b_input &&
				!(security_disable_bit & mode_a_input);
			r_ff.secured <= !security_disable_bit;
		end else if (clk_en) begin
			r_ff <= nxt_r;
		end
	end

	assign txd = r_ff.txd;
	assign addr14_force_low = r_ff.a14_low;
	assign ram_we = r_ff.ram_we;
	assign ram_addr = r_ff.ram_addr;
	assign ram_wdata = r_ff.ram_wdata;
	assign jump_valid = r_ff.jump_valid;
	assign jump_addr = r_ff.jump_addr;
	assign index_x = r_ff.ix;
	assign index_y = r_ff.iy;
	assign s_axi_awready = r_ff.awready;
	assign s_axi_wready = r_ff.wready;
	assign s_axi_bresp = r_ff.bresp;
	assign s_axi_bvalid = r_ff.bvalid;
	assign s_axi_arready = r_ff.arready;
	assign s_axi_rdata = r_ff.rdata;
	assign s_axi_rresp = r_ff.rresp;
	assign s_axi_rvalid = r_ff.rvalid;

	// pointer advances by one per store
	ptr_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && r_ff.ram_we |=> r_ff.ptr == r_ff.ram_addr + 16'h0001)
		else $error("ram pointer did not advance");
	echo_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
		r_ff.ram_we |-> r_ff.st == ST_ECHO)
		else $error("store not followed by echo");
	vector_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && r_ff.special_mode_flag && vector_fetch |=> addr14_force_low)
		else $error("vector fetch not relocated");
	eeprom_jump_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && r_ff.st == ST_FIRST && r_ff.rx_done && r_ff.rx_byte == 8'h00
		|=> jump_valid && jump_addr == 16'hB600)
		else $error("break did not jump to eeprom");
	rate_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && r_ff.st == ST_FIRST && r_ff.rx_done && r_ff.rx_byte == 8'hE0
		|=> r_ff.slow)
		else $error("rate not switched");
	slow_tmo_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && r_ff.st == ST_LOAD && r_ff.rx_done && r_ff.slow
		|=> r_ff.tmo == 17'(sbl_pkg::SLOW_TMO_E))
		else $error("slow timeout constant wrong");
	ram_jump_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && r_ff.st == ST_FINISH |=> jump_valid && jump_addr == 16'h0000
		&& index_x == 16'h1000)
		else $error("finish did not jump to ram");
	enables_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		r_ff.st == ST_FIRST |-> r_ff.rx_en && r_ff.tx_en && r_ff.port_wired_or_select)
		else $error("port not configured");
endmodule : sbl_loader

/* File: sbl_host_model.sv */
// host partner for the loader: sends 8n1 frames on the device receive line, decodes its echo
// assumes send_stb/send_byte change just after aclk edges; BIT_CLKS is one bit time in aclk
`timescale 1ns/1ps
module sbl_host_model #(
	parameter int BIT_CLKS = 12800
) (
	input wire logic aclk,
	input wire logic dev_txd,
	input wire logic loop_en,
	input wire logic send_stb,
	input wire logic [7:0] send_byte,
	output logic busy,
	output logic host_rxd,
	output logic rx_stb,
	output logic [7:0] rx_byte
);
	logic line_ff = 1'b1;
	logic prev_ff = 1'b1;
	logic [9:0] frame;
	initial busy = 1'b0;
	initial rx_stb = 1'b0;
	initial rx_byte = 8'h00;
	// loopback ties the device transmitter back to its own receiver, as a jumper would
	assign host_rxd = loop_en ? dev_txd : line_ff;
	// start low, lsb first, stop high
	// line idles high after a frame, so falling silent ends the load
	always begin
		@(posedge aclk);
		if (send_stb && !busy) begin
			busy <= 1'b1;
			frame = {1'b1, send_byte, 1'b0};
			for (int i = 0; i < 10; i++) begin
				line_ff <= frame[i];
				repeat (BIT_CLKS) @(posedge aclk);
			end
			busy <= 1'b0;
		end
	end
	// echo decoder samples mid-bit; a low stop bit still reports, so a break reads as 00
	always begin
		@(posedge aclk);
		if (prev_ff === 1'b1 && dev_txd === 1'b0) begin
			repeat (BIT_CLKS / 2) @(posedge aclk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge aclk);
				rx_byte <= {dev_txd, rx_byte[7:1]};
			end
			repeat (BIT_CLKS) @(posedge aclk);
			rx_stb <= 1'b1;
			@(posedge aclk);
			rx_stb <= 1'b0;
		end
		prev_ff = dev_txd;
	end
endmodule : sbl_host_model

/* File: sbl_loader_tb.sv */
// self-checking bench: strap decode, vector relocation, break loopback, one-byte download
// assumes the host model on rxd/txd; serial timing is fixed, so the run is long by nature
`timescale 1ns/1ps
module sbl_loader_tb;
	localparam int BIT = 12800;
	localparam int TMO = sbl_pkg::FAST_TMO_E * sbl_pkg::E_DIV;
	localparam int LIMIT = 2500000;
	logic aclk = 1'b0, aresetn = 1'b0, mode_a_input = 1'b0, mode_b_input = 1'b0;
	logic security_disable_bit = 1'b1, vector_fetch = 1'b0, loop_en = 1'b0, send_stb = 1'b0;
	logic [7:0] send_byte = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_byte;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lfsr_st = 32'h512AB1FC;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic txd, host_rxd, addr14_force_low, ram_we, jump_valid, busy, rx_stb;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] ram_wdata;
	logic [15:0] ram_addr, jump_addr, index_x, index_y, je;
	logic [31:0] rexp[$], rmsk[$];
	logic [1:0] rrq[$], brq[$];
	logic [23:0] wq[$];
	logic [7:0] eq[$];
	logic [15:0] jq[$];
	int error_cnt = 0, n_checks = 0, cyc = 0, we_cyc = 0;
	sbl_loader DUT (.aclk, .aresetn, .clk_en(1'b1), .mode_a_input, .mode_b_input,
		.security_disable_bit, .vector_fetch, .rxd(host_rxd), .txd, .addr14_force_low,
		.ram_we, .ram_addr, .ram_wdata, .jump_valid, .jump_addr, .index_x, .index_y,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	sbl_host_model #(.BIT_CLKS(BIT)) host (.aclk, .dev_txd(txd), .loop_en, .send_stb,
		.send_byte, .busy, .host_rxd(host_rxd), .rx_stb, .rx_byte);
	always #5 aclk = ~aclk;
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		cmp_word({31'h0, got}, {31'h0, exp}, what);
	endtask : cmp_bit
	task automatic close_out();
		if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	// straps stand through three reset edges so they are latched as reset leaves
	task automatic rst(input logic b, input logic a, input logic s);
		aresetn <= 1'b0;
		mode_b_input <= b;
		mode_a_input <= a;
		security_disable_bit <= s;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : rst
	// each channel drops its valid at the edge that takes it; one idle edge ends the task
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		brq.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		rexp.push_back(e & m);
		rmsk.push_back(m);
		rrq.push_back(er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axr
	task automatic host_send(input logic [7:0] b);
		send_byte <= b;
		send_stb <= 1'b1;
		do @(posedge aclk); while (!busy);
		send_stb <= 1'b0;
		do @(posedge aclk); while (busy);
	endtask : host_send
	// jump is sticky; two more bit times let the echo decoder finish its frame
	task automatic wait_jump();
		while (jump_valid !== 1'b1) @(posedge aclk);
		repeat (2 * BIT) @(posedge aclk);
	endtask : wait_jump
	// result watcher: each result seen retires the oldest expectation of its kind
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (s_axi_bvalid && s_axi_bready) cmp_word(32'(s_axi_bresp), 32'(brq.pop_front()), "bresp");
		if (s_axi_rvalid && s_axi_rready) begin
			cmp_word(32'(s_axi_rresp), 32'(rrq.pop_front()), "rresp");
			cmp_word(s_axi_rdata & rmsk.pop_front(), rexp.pop_front(), "rdata");
		end
		if (ram_we) begin
			we_cyc <= cyc;
			cmp_word({8'h0, ram_addr, ram_wdata}, wq.size() > 0 ? {8'h0, wq.pop_front()} : '1, "store");
		end
		if (rx_stb) cmp_word(32'(rx_byte), eq.size() > 0 ? 32'(eq.pop_front()) : '1, "echo");
		if ($rose(jump_valid)) begin
			je = jq.size() > 0 ? jq.pop_front() : 16'hFFFF;
			cmp_word(32'(jump_addr), 32'(je), "jump target");
			if (je === sbl_pkg::RAM_START) begin
				cmp_word({index_x, index_y}, {sbl_pkg::PRESET_X, sbl_pkg::PRESET_Y}, "index");
				cmp_bit(cyc - we_cyc > TMO - 2 * BIT && cyc - we_cyc < TMO + 2 * BIT, 1'b1, "idle");
			end
		end
	end
	// hang guard: a run this long means a handshake never came
	always @(posedge aclk) begin
		if (cyc == LIMIT) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		logic [2:0] modes[4] = '{3'b101, 3'b111, 3'b011, 3'b110};
		logic b, a, s;
		logic [7:0] d;
		// strap decode, boot memory write access and vector relocation outside bootstrap
		foreach (modes[k]) begin
			{b, a, s} = modes[k];
			lfsr_st = lfsr_next(lfsr_st);
			rst(b, a, s);
			axr(sbl_pkg::REG_MODE, {29'h0, a & s, ~b, 1'b0}, 32'h7, 2'h0);
			axw(sbl_pkg::REG_MODE, {lfsr_st[31:8], 5'h0, a & s, ~b, 1'b1}, 2'h0);
			axr(sbl_pkg::REG_MODE, {29'h0, a & s, ~b, ~b}, 32'h7, 2'h0);
			@(posedge aclk);
			vector_fetch <= 1'b1;
			@(posedge aclk);
			vector_fetch <= 1'b0;
			#1 cmp_bit(addr14_force_low, ~b, "vector relocation");
		end
		axr(8'h20, 32'h0, 32'hFFFFFFFF, 2'h2);
		axw(8'h20, lfsr_st, 2'h2);
		// looped-back break reads as 00 and sends control to eeprom
		loop_en <= 1'b1;
		eq.push_back(sbl_pkg::BREAK_CHAR);
		jq.push_back(sbl_pkg::EEPROM_START);
		rst(1'b0, 1'b0, 1'b1);
		wait_jump();
		axr(sbl_pkg::REG_MODE, 32'hB, 32'hF, 2'h0);
		axr(sbl_pkg::REG_STAT, 32'h30, 32'h30, 2'h0);
		// download of one random byte at the default rate
		loop_en <= 1'b0;
		eq.push_back(sbl_pkg::BREAK_CHAR);
		rst(1'b0, 1'b0, 1'b1);
		repeat (TMO + 4 * BIT) @(posedge aclk);
		cmp_bit(jump_valid, 1'b0, "early jump");
		host_send(sbl_pkg::ALL_ONES);
		lfsr_st = lfsr_next(lfsr_st);
		d = lfsr_st[7:0];
		wq.push_back({sbl_pkg::RAM_START, d});
		eq.push_back(d);
		jq.push_back(sbl_pkg::RAM_START);
		host_send(d);
		wait_jump();
		axr(sbl_pkg::REG_RAMPTR, 32'h1, 32'hFFFF, 2'h0);
		close_out();
	end
endmodule : sbl_loader_tb
